// [eth_error_thermal.sv]
// catastrophic error and processor-hot pin logic
`timescale 1ns/1ps
`default_nettype none

module eth_error_thermal
    import eth_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire eth_err_type   err_event,
    input  wire eth_therm_type therm,
    input  wire logic          processor_hot_n_in,
    output var  logic          catastrophic_error_n_out,
    output var  logic          catastrophic_error_n_oe,
    output var  logic          processor_hot_n_out,
    output var  logic          processor_hot_n_oe,
    output var  logic          thermal_control_circuit_active
);

    eth_state_type state;
    eth_state_type next_state;
    logic [4:0]    pulse_cnt;
    logic          hot_meta;
    logic          hot_sync_n;
    logic          own_hot;
    logic          ext_hot_req;

    // saturating step shared by the pulse timer and the run counter
    function automatic logic [4:0] step_count(input logic [4:0] value);
        if (value == 5'h1f) begin
            return value;
        end
        return value + 5'h01;
    endfunction

    // internal class outranks a pulse already running: the error is fatal
    always_comb begin
        next_state = state;
        unique case (state)
            ETH_IDLE: begin
                if (err_event.internal_error_class) begin
                    next_state = ETH_HOLD;
                end else if (err_event.machine_check_error_class) begin
                    next_state = ETH_PULSE;
                end
            end
            ETH_PULSE: begin
                if (err_event.internal_error_class) begin
                    next_state = ETH_HOLD;
                end else if (pulse_cnt == MCE_CNT_LAST) begin
                    next_state = ETH_IDLE;
                end
            end
            ETH_HOLD: next_state = ETH_HOLD;
            default:  next_state = ETH_IDLE;
        endcase
    end

    // warm and cold reset both arrive on rst
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ETH_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pulse_cnt <= MCE_CNT_RESET;
        end else if (state == ETH_PULSE && next_state == ETH_PULSE) begin
            pulse_cnt <= step_count(pulse_cnt);
        end else begin
            pulse_cnt <= MCE_CNT_RESET;
        end
    end

    // pin level registered; out stays 0 so only the enable toggles
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            catastrophic_error_n_oe  <= 1'b0;
            catastrophic_error_n_out <= 1'b0;
        end else begin
            catastrophic_error_n_oe  <= (next_state != ETH_IDLE);
            catastrophic_error_n_out <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hot_meta   <= 1'b1;
            hot_sync_n <= 1'b1;
        end else begin
            hot_meta   <= processor_hot_n_in;
            hot_sync_n <= hot_meta;
        end
    end

    // own drive masks the sampled line; a short blind spot after release
    // of our own drive is accepted rather than self-triggering
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            own_hot             <= 1'b0;
            processor_hot_n_oe  <= 1'b0;
            processor_hot_n_out <= 1'b0;
        end else begin
            own_hot             <= therm.sensor_at_max;
            processor_hot_n_oe  <= therm.sensor_at_max;
            processor_hot_n_out <= 1'b0;
        end
    end

    logic [1:0] own_hist;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            own_hist <= 2'b00;
        end else begin
            own_hist <= {own_hist[0], own_hot};
        end
    end

    assign ext_hot_req = !hot_sync_n && !own_hot && (own_hist == 2'b00);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            thermal_control_circuit_active <= 1'b0;
        end else begin
            thermal_control_circuit_active <=
                (therm.sensor_at_max && therm.circuit_enable) || ext_hot_req;
        end
    end

    // helper state for the checks below; no pin depends on it
    logic [4:0] ce_run;
    logic       int_err_seen;

    // counts edges with the error pin held; saturates during a hold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ce_run <= MCE_CNT_RESET;
        end else if (catastrophic_error_n_oe) begin
            ce_run <= step_count(ce_run);
        end else begin
            ce_run <= MCE_CNT_RESET;
        end
    end

    // a fatal internal event stays on record until reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            int_err_seen <= 1'b0;
        end else if (err_event.internal_error_class) begin
            int_err_seen <= 1'b1;
        end
    end

    sequence s_mce_start;
        state == ETH_IDLE && !err_event.internal_error_class
            && err_event.machine_check_error_class;
    endsequence

    sequence s_pulse_end;
        $fell(catastrophic_error_n_oe);
    endsequence

    a_mce_start: assert property (@(posedge mclk) disable iff (rst)
        s_mce_start |=> catastrophic_error_n_oe)
        else $error("machine-check event not signalled");

    a_mce_pulse_len: assert property (@(posedge mclk) disable iff (rst)
        s_pulse_end |-> ce_run == 5'(MCE_PULSE_CYCLES))
        else $error("machine-check pulse not 16 cycles");

    a_mce_release: assert property (@(posedge mclk) disable iff (rst)
        (ce_run == 5'(MCE_PULSE_CYCLES)) && !int_err_seen |-> !catastrophic_error_n_oe)
        else $error("machine-check pulse not released");

    a_int_err_held: assert property (@(posedge mclk) disable iff (rst)
        state == ETH_HOLD |-> catastrophic_error_n_oe ##1 catastrophic_error_n_oe)
        else $error("internal error indication released");

    a_int_err_kept: assert property (@(posedge mclk) disable iff (rst)
        int_err_seen |-> catastrophic_error_n_oe)
        else $error("internal error indication lost before reset");

    a_err_cause: assert property (@(posedge mclk) disable iff (rst)
        $rose(catastrophic_error_n_oe) |-> $past(err_event.internal_error_class)
            || $past(err_event.machine_check_error_class))
        else $error("catastrophic error without cause");

    a_od_low_only: assert property (@(posedge mclk) disable iff (rst)
        !catastrophic_error_n_out && !processor_hot_n_out)
        else $error("open-drain pin driven high");

    a_hot_drive: assert property (@(posedge mclk) disable iff (rst)
        therm.sensor_at_max |=> processor_hot_n_oe)
        else $error("processor hot not driven at max temperature");

    a_ext_request: assert property (@(posedge mclk) disable iff (rst)
        ext_hot_req |=> thermal_control_circuit_active)
        else $error("external hot request ignored");

    a_hot_release: assert property (@(posedge mclk) disable iff (rst)
        !therm.sensor_at_max |=> !processor_hot_n_oe)
        else $error("processor hot driven without cause");

    a_own_masked: assert property (@(posedge mclk) disable iff (rst)
        (own_hot && !therm.circuit_enable) |=> !thermal_control_circuit_active)
        else $error("own processor hot taken as request");

    a_circuit_on: assert property (@(posedge mclk) disable iff (rst)
        (therm.sensor_at_max && therm.circuit_enable) |=> thermal_control_circuit_active)
        else $error("thermal circuit not activated");

endmodule // eth_error_thermal

`default_nettype wire

// [eth_pkg.sv]
// package for the error and thermal signalling pin block
package eth_pkg;
    // assertion time of a machine-check class error pulse
    localparam int unsigned MCE_PULSE_CYCLES = 16;
    localparam logic [4:0]  MCE_CNT_RESET    = 5'h00;
    localparam logic [4:0]  MCE_CNT_LAST     = 5'(MCE_PULSE_CYCLES - 1);

    typedef enum logic [2:0] {
        ETH_IDLE  = 3'b001,
        ETH_PULSE = 3'b010,
        ETH_HOLD  = 3'b100
    } eth_state_type;

    // error events from the machine-check logic
    typedef struct packed {
        logic machine_check_error_class;
        logic internal_error_class;
    } eth_err_type;

    // thermal inputs from the sensor side
    typedef struct packed {
        logic sensor_at_max;
        logic circuit_enable;
    } eth_therm_type;
endpackage : eth_pkg

// [eth_platform_model.sv]
// platform controller model on the shared processor-hot line
`timescale 1ns/1ps
`default_nettype none
module eth_platform_model (
    input  wire logic hot_req,
    input  wire logic dev_oe,
    input  wire logic dev_out,
    output var  logic pin
);
    // pull-up to high; device and platform pull low as a wired-and
    always_comb pin = (dev_oe ? dev_out : 1'b1) & ~hot_req;
endmodule // eth_platform_model
`default_nettype wire

// [eth_error_thermal_bench.sv]
// testbench for the error and thermal pin block
`timescale 1ns/1ps
`default_nettype none
module eth_error_thermal_bench
    import eth_pkg::*;
();
    logic          mclk    = 1'b0;
    logic          rst     = 1'b1;
    logic          hot_req = 1'b0;
    logic          pin, ce_out, ce_oe, ph_out, ph_oe, act;
    eth_err_type   err     = '0;
    eth_therm_type th      = '0;
    logic [31:0]   lfsr    = 32'h0000_4096;
    int            miscompares = 0;
    int            total_checks = 0;
    wire logic     ce_pin  = ce_oe ? ce_out : 1'b1;
    always #5 mclk = ~mclk;
    eth_error_thermal dut (.mclk(mclk), .rst(rst), .err_event(err), .therm(th),
        .processor_hot_n_in(pin), .catastrophic_error_n_out(ce_out),
        .catastrophic_error_n_oe(ce_oe), .processor_hot_n_out(ph_out),
        .processor_hot_n_oe(ph_oe), .thermal_control_circuit_active(act));
    eth_platform_model plat (.hot_req(hot_req), .dev_oe(ph_oe), .dev_out(ph_out), .pin(pin));
    function automatic logic [31:0] next_lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // pin level expected i cycles after a machine-check event
    function automatic logic exp_cat(input int i);
        return (i <= int'(MCE_PULSE_CYCLES)) ? 1'b0 : 1'b1;
    endfunction
    task automatic chk(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
            miscompares++;
        end
    endtask
    task automatic final_report;
        if (miscompares == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic mce_pulse;
        err.machine_check_error_class <= 1'b1;
        for (int i = 1; i <= 17; i++) begin
            @(negedge mclk);
            // a retrigger in mid-pulse must not stretch it
            err.machine_check_error_class <= (i == 5);
            chk("cat_pin", exp_cat(i), ce_pin);
        end
    endtask
    initial begin
        #20us;
        miscompares++;
        final_report;
    end
    initial begin
        repeat (6) @(negedge mclk);
        rst <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            lfsr = next_lfsr(lfsr);
            repeat (lfsr[2:0]) @(negedge mclk);
            mce_pulse();
            th.sensor_at_max <= 1'b1;
            th.circuit_enable <= lfsr[3];
            @(negedge mclk);
            chk("hot_oe", 1'b1, ph_oe);
            chk("hot_pin", 1'b0, pin);
            chk("circ_on", lfsr[3], act);
            chk("cat_idle", 1'b1, ce_pin);
            th.sensor_at_max <= 1'b0;
            @(negedge mclk);
            chk("circ_off", 1'b0, act);
            repeat (4) @(negedge mclk);
            hot_req <= 1'b1;
            repeat (3) @(negedge mclk);
            chk("ext_circ", 1'b1, act);
            chk("ext_oe", 1'b0, ph_oe);
            hot_req <= 1'b0;
            repeat (4) @(negedge mclk);
            chk("ext_off", 1'b0, act);
        end
        // internal class arriving in mid-pulse turns into a hold
        err <= 2'b10;
        repeat (3) @(negedge mclk);
        err <= 2'b01;
        @(negedge mclk);
        err <= 2'b00;
        repeat (40) @(negedge mclk);
        chk("int_hold", 1'b0, ce_pin);
        rst <= 1'b1;
        @(negedge mclk);
        rst <= 1'b0;
        chk("int_rst", 1'b1, ce_pin);
        // first event at the very edge that ends reset
        mce_pulse();
        final_report;
    end
endmodule // eth_error_thermal_bench
`default_nettype wire
